// [src/pin_level_port_pkg.sv]
// shared constants and types for the eight-bit port block
package pin_level_port_pkg;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_PIN_LEVEL = 8'h00;
	localparam logic [7:0] OFS_LATCH     = 8'h04;
	localparam logic [7:0] OFS_DIR       = 8'h08;
	localparam logic [7:0] OFS_CONV_CTRL = 8'h0C;
	localparam logic [7:0] OFS_OSC_CFG   = 8'h10;
	// ------------------------------------------------------------
	// widths and field positions
	// ------------------------------------------------------------
	localparam int PORT_W      = 8;
	localparam int PIN_TMR     = 4;
	localparam int PIN_VREF    = 2;
	localparam int PIN_SIX     = 6;
	localparam int PIN_SEVEN   = 7;
	localparam int SEL_LSB     = 0;
	localparam int SEL_MSB     = 3;
	localparam int REF_LSB     = 4;
	localparam int REF_MSB     = 5;
	localparam int OSC_MODE_LSB = 0;
	localparam int OSC_MODE_MSB = 3;
	localparam int REF_OUT_BIT  = 4;
	// converter control bits 7:6 unimplemented
	localparam logic [7:0] CONV_MASK = 8'h3F;
	// pins whose direction works plainly
	localparam logic [7:0] PLAIN_MASK = 8'h2B;
	// analog when select plus channel is below this
	localparam logic [3:0] ANALOG_LIMIT = 4'h7;
	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_DIR   = 8'hFF;
	localparam logic [7:0] RST_CONV  = 8'h00;
	// ------------------------------------------------------------
	// oscillator modes
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		OSC_LP      = 4'h0,
		OSC_XT      = 4'h1,
		OSC_HS      = 4'h2,
		OSC_RC      = 4'h3,
		OSC_RC_IO   = 4'h4,
		OSC_EC      = 4'h5,
		OSC_EC_IO   = 4'h6,
		OSC_INT_IO1 = 4'h7,
		OSC_INT_IO2 = 4'h8
	} osc_mode_t;
	localparam osc_mode_t RST_OSC = OSC_INT_IO2;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ  = 250;
	localparam int FOSC_DIV = 4;
	localparam int HALF_CNT = FOSC_DIV / 2;
	// ------------------------------------------------------------
	// pin drive carrier
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] oe_n;
	} pin_drive_t;
endpackage

// [src/pin_sync.sv]
// two-stage synchroniser, one per pin
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
	parameter int W = 8
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	genvar b;
	generate
		for (b = 0; b < W; b++) begin : g_bit
			logic meta;
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta      <= 1'b0;
					sync_o[b] <= 1'b0;
				end else begin
					meta      <= async_i[b];
					sync_o[b] <= meta;
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// [src/pin_level_port_top.sv]
// eight-bit port with analog select, timer input and clock pin
// Behaviour
// - eight bits in each port register
// - direction one puts pin driver off
// - direction zero drives the latch value
// - pin read gives pins, write sets latch
// - latch read returns latched value
// - pin four feeds timer, open drain
// - oscillator-owned pins six, seven read zero
// - pin six/seven io only in io modes
// - pin six gives cycle clock otherwise
// - four-bit field selects analog pins
// - reset leaves analog pins reading zero
// - analog pin loses digital input only
// - direction still rules analog pins' drivers
// - reference output disables pin two
// - control layout: ref select, pin select
`timescale 1ns/10ps
`default_nettype none
module pin_level_port_top (
	input  wire logic        SYS_CLK_I,
	input  wire logic        RESET_N_I,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic      [31:0] WB_DAT_O,
	output logic             WB_ACK_O,
	input  wire logic [7:0]  PIN_IN_I,
	output logic      [7:0]  PIN_OUT_O,
	output logic      [7:0]  PIN_OE_N_O,
	output logic             TIMER_CLK_O,
	output logic      [5:0]  ANALOG_SEL_O,
	output logic      [1:0]  VREF_SEL_O
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	logic [7:0]           lat;
	logic [7:0]           dir;
	logic [7:0]           conv;
	pin_level_port_pkg::osc_mode_t osc;
	logic                 ref_out;
	logic [7:0]           pin_s;
	logic                 cyc_clk;
	logic [1:0]           div_cnt;
	logic                 io6;
	logic                 io7;
	logic [5:0]           analog;
	logic [7:0]           dig_in;
	logic [7:0]           own_mask;
	logic [7:0]           pin_rd;
	logic [31:0]          next_dat;
	pin_level_port_pkg::pin_drive_t next_drv;
	logic                 req;
	logic                 wr;
	logic                 wr0;
	logic [4:0]           sel;

	pin_sync #(
		.W(pin_level_port_pkg::PORT_W)
	) u_sync (
		.clk_i  (SYS_CLK_I),
		.rst_n_i(RESET_N_I),
		.async_i(PIN_IN_I),
		.sync_o (pin_s)
	);

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign wr  = req & WB_WE_I;
	assign wr0 = wr & WB_SEL_I[0];
	assign sel = {1'b0, conv[pin_level_port_pkg::SEL_MSB:pin_level_port_pkg::SEL_LSB]};

	// ------------------------------------------------------------
	// oscillator pin ownership
	// ------------------------------------------------------------
	always_comb begin
		io6 = (osc == pin_level_port_pkg::OSC_RC_IO) |
			(osc == pin_level_port_pkg::OSC_INT_IO2) |
			(osc == pin_level_port_pkg::OSC_EC_IO);
		io7 = (osc == pin_level_port_pkg::OSC_INT_IO1) |
			(osc == pin_level_port_pkg::OSC_INT_IO2);
		own_mask = 8'hFF;
		own_mask[pin_level_port_pkg::PIN_SIX]   = io6;
		own_mask[pin_level_port_pkg::PIN_SEVEN] = io7;
	end

	// ------------------------------------------------------------
	// analog selection
	// ------------------------------------------------------------
	always_comb begin
		analog = 6'h00;
		analog[0] = (sel + 5'h00) < 5'(pin_level_port_pkg::ANALOG_LIMIT);
		analog[1] = (sel + 5'h01) < 5'(pin_level_port_pkg::ANALOG_LIMIT);
		analog[2] = (sel + 5'h02) < 5'(pin_level_port_pkg::ANALOG_LIMIT);
		analog[3] = (sel + 5'h03) < 5'(pin_level_port_pkg::ANALOG_LIMIT);
		analog[5] = (sel + 5'h04) < 5'(pin_level_port_pkg::ANALOG_LIMIT);
	end

	// ------------------------------------------------------------
	// digital input path
	// ------------------------------------------------------------
	always_comb begin
		dig_in = {io7, io6, ~analog[5], 1'b1, ~analog[3],
			~(analog[2] | ref_out), ~analog[1], ~analog[0]};
		pin_rd = pin_s & dig_in;
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb begin
		next_dat = 32'h0000_0000;
		case (WB_ADR_I)
			pin_level_port_pkg::OFS_PIN_LEVEL: begin
				next_dat[7:0] = pin_rd;
			end
			pin_level_port_pkg::OFS_LATCH: begin
				next_dat[7:0] = lat & own_mask;
			end
			pin_level_port_pkg::OFS_DIR: begin
				next_dat[7:0] = dir & own_mask;
			end
			pin_level_port_pkg::OFS_CONV_CTRL: begin
				next_dat[7:0] = conv & pin_level_port_pkg::CONV_MASK;
			end
			pin_level_port_pkg::OFS_OSC_CFG: begin
				next_dat[3:0] = osc;
				next_dat[pin_level_port_pkg::REF_OUT_BIT] = ref_out;
			end
			default: begin
				next_dat = 32'h0000_0000;
			end
		endcase
	end

	// ------------------------------------------------------------
	// bus answer
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= req;
			if (req && !WB_WE_I) begin
				WB_DAT_O <= next_dat;
			end
		end
	end

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			lat <= pin_level_port_pkg::RST_LATCH;
		end else if (wr0 && (WB_ADR_I == pin_level_port_pkg::OFS_PIN_LEVEL ||
			WB_ADR_I == pin_level_port_pkg::OFS_LATCH)) begin
			lat <= WB_DAT_I[7:0];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			dir <= pin_level_port_pkg::RST_DIR;
		end else if (wr0 && WB_ADR_I == pin_level_port_pkg::OFS_DIR) begin
			dir <= WB_DAT_I[7:0];
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			conv <= pin_level_port_pkg::RST_CONV;
		end else if (wr0 && WB_ADR_I == pin_level_port_pkg::OFS_CONV_CTRL) begin
			conv <= WB_DAT_I[7:0] & pin_level_port_pkg::CONV_MASK;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			osc     <= pin_level_port_pkg::RST_OSC;
			ref_out <= 1'b0;
		end else if (wr0 && WB_ADR_I == pin_level_port_pkg::OFS_OSC_CFG) begin
			osc     <= pin_level_port_pkg::osc_mode_t'(WB_DAT_I[3:0]);
			ref_out <= WB_DAT_I[pin_level_port_pkg::REF_OUT_BIT];
		end
	end

	// ------------------------------------------------------------
	// cycle clock divider
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			div_cnt <= 2'h0;
			cyc_clk <= 1'b0;
		end else if (div_cnt == 2'(pin_level_port_pkg::HALF_CNT - 1)) begin
			div_cnt <= 2'h0;
			cyc_clk <= ~cyc_clk;
		end else begin
			div_cnt <= div_cnt + 2'h1;
		end
	end

	// ------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------
	always_comb begin
		next_drv.level = lat;
		next_drv.oe_n  = dir;
		next_drv.oe_n[pin_level_port_pkg::PIN_VREF] =
			dir[pin_level_port_pkg::PIN_VREF] | ref_out;
		next_drv.level[pin_level_port_pkg::PIN_TMR] = 1'b0;
		next_drv.oe_n[pin_level_port_pkg::PIN_TMR] = dir[pin_level_port_pkg::PIN_TMR] |
			lat[pin_level_port_pkg::PIN_TMR];
		if (!io6) begin
			next_drv.level[pin_level_port_pkg::PIN_SIX] = cyc_clk;
			next_drv.oe_n[pin_level_port_pkg::PIN_SIX]  = 1'b0;
		end
		if (!io7) begin
			next_drv.oe_n[pin_level_port_pkg::PIN_SEVEN] = 1'b1;
		end
	end

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			PIN_OUT_O    <= 8'h00;
			PIN_OE_N_O   <= 8'hFF;
			TIMER_CLK_O  <= 1'b0;
			ANALOG_SEL_O <= 6'h00;
			VREF_SEL_O   <= 2'h0;
		end else begin
			PIN_OUT_O    <= next_drv.level;
			PIN_OE_N_O   <= next_drv.oe_n;
			TIMER_CLK_O  <= pin_s[pin_level_port_pkg::PIN_TMR];
			ANALOG_SEL_O <= analog;
			VREF_SEL_O   <= conv[pin_level_port_pkg::REF_MSB:pin_level_port_pkg::REF_LSB];
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);

	property p_ack_once;
		req |=> WB_ACK_O ##1 !WB_ACK_O;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack not a single pulse after request");

	property p_hiz;
		1 |=> (($past(dir) & ~PIN_OE_N_O & pin_level_port_pkg::PLAIN_MASK)
			== 8'h00);
	endproperty
	a_hiz: assert property (p_hiz)
		else $error("input pin is being driven");

	property p_drive;
		1 |=> (((~$past(dir)) & pin_level_port_pkg::PLAIN_MASK &
			(PIN_OE_N_O | (PIN_OUT_O ^ $past(lat)))) == 8'h00);
	endproperty
	a_drive: assert property (p_drive)
		else $error("output pin not driving latch");

	property p_open_drain;
		!PIN_OE_N_O[4] |-> !PIN_OUT_O[4] && !$past(lat[4]) &&
			!$past(dir[4]);
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("pin four drove high or without cause");

	property p_latch_wr;
		(wr0 && WB_ADR_I == pin_level_port_pkg::OFS_PIN_LEVEL) |=>
			lat == $past(WB_DAT_I[7:0]) ##2 lat == $past(WB_DAT_I[7:0], 3);
	endproperty
	a_latch_wr: assert property (p_latch_wr)
		else $error("pin level write missed the latch");

	property p_osc_read;
		(req && !WB_WE_I && WB_ADR_I == pin_level_port_pkg::OFS_LATCH && !io7)
			|=> !WB_DAT_O[7] && WB_ACK_O;
	endproperty
	a_osc_read: assert property (p_osc_read)
		else $error("oscillator pin latch read not zero");

	property p_analog_read;
		(req && !WB_WE_I && WB_ADR_I == pin_level_port_pkg::OFS_PIN_LEVEL &&
			analog[0]) |=> !WB_DAT_O[0];
	endproperty
	a_analog_read: assert property (p_analog_read)
		else $error("analog pin read not zero");

	property p_clk_out;
		(!io6 && $rose(cyc_clk)) |-> cyc_clk[*2] ##1 !cyc_clk[*2];
	endproperty
	a_clk_out: assert property (p_clk_out)
		else $error("cycle clock is not a quarter rate");

	property p_clk_pin;
		!io6 |=> !PIN_OE_N_O[6] && PIN_OUT_O[6] == $past(cyc_clk);
	endproperty
	a_clk_pin: assert property (p_clk_pin)
		else $error("pin six not carrying cycle clock");

	property p_vref;
		ref_out |=> PIN_OE_N_O[pin_level_port_pkg::PIN_VREF];
	endproperty
	a_vref: assert property (p_vref)
		else $error("pin two driven with reference on");

	property p_conv_top;
		WB_ACK_O && $past(!WB_WE_I && WB_ADR_I ==
			pin_level_port_pkg::OFS_CONV_CTRL) |-> WB_DAT_O[7:6] == 2'h0;
	endproperty
	a_conv_top: assert property (p_conv_top)
		else $error("unimplemented control bits not zero");

	property p_timer_live;
		(req && !WB_WE_I && WB_ADR_I == pin_level_port_pkg::OFS_PIN_LEVEL) |=>
			WB_DAT_O[pin_level_port_pkg::PIN_TMR] == $past(pin_s[pin_level_port_pkg::PIN_TMR]);
	endproperty
	a_timer_live: assert property (p_timer_live)
		else $error("pin four input masked on read");

	property p_dir_own;
		(req && !WB_WE_I && WB_ADR_I == pin_level_port_pkg::OFS_DIR && !io6) |=>
			!WB_DAT_O[pin_level_port_pkg::PIN_SIX] && WB_ACK_O;
	endproperty
	a_dir_own: assert property (p_dir_own)
		else $error("oscillator pin direction read not zero");

	property p_analog_drive;
		(analog[0] && !dir[0]) |=>
			!PIN_OE_N_O[0] && PIN_OUT_O[0] == $past(lat[0]);
	endproperty
	a_analog_drive: assert property (p_analog_drive)
		else $error("analog pin lost its output driver");
endmodule
`default_nettype wire

// [bench/board_pins.sv]
// board-side driver model resolving each port pin
`timescale 1ns/10ps
`default_nettype none
module board_pins (
	input  wire logic [7:0] pin_out_i,
	input  wire logic [7:0] pin_oe_n_i,
	input  wire logic [7:0] ext_i,
	output logic      [7:0] pin_o
);
	// the board drives every pin that the port has released
	assign pin_o = (~pin_oe_n_i & pin_out_i) | (pin_oe_n_i & ext_i);
endmodule
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the eight-bit port block
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        clk      = 1'b0;
	logic        rst_n    = 1'b0;
	logic        cyc      = 1'b0;
	logic        stb      = 1'b0;
	logic        we       = 1'b0;
	logic [7:0]  adr      = 8'h00;
	logic [3:0]  bsel     = 4'h1;
	logic [31:0] wdat     = 32'h0;
	logic [7:0]  ext      = 8'h00;
	logic [31:0] rdat;
	logic        ack;
	logic [7:0]  pin_in;
	logic [7:0]  pin_out;
	logic [7:0]  pin_oe_n;
	logic        tmr;
	logic [5:0]  asel;
	logic [1:0]  vsel;
	logic [7:0]  lat      = 8'h00;
	logic [7:0]  dir      = 8'hFF;
	logic [7:0]  q;
	logic [7:0]  w;
	logic [3:0]  sel      = 4'h0;
	logic [3:0]  osc      = 4'h8;
	logic        cv       = 1'b0;
	logic [1:0]  ref_v;
	int          n_fail   = 0;
	int          compares = 0;
	int          cycles   = 0;
	int          seed     = 71660;
	int          hi;

	pin_level_port_top i_dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(bsel),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .PIN_IN_I(pin_in),
		.PIN_OUT_O(pin_out), .PIN_OE_N_O(pin_oe_n), .TIMER_CLK_O(tmr),
		.ANALOG_SEL_O(asel), .VREF_SEL_O(vsel));
	board_pins i_board (.pin_out_i(pin_out), .pin_oe_n_i(pin_oe_n),
		.ext_i(ext), .pin_o(pin_in));

	always #2 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			print_verdict();
		end
	end

	// ------------------------------------------------------------
	// bus, compare and verdict tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		if (n_fail == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] e,
		input logic [7:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, e, g);
		end
	endtask

	task automatic wb(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] r);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		r = rdat[7:0];
		if (!wr) chk("upper bits", 8'h00, {7'h00, |rdat[31:8]});
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	// ------------------------------------------------------------
	// expectation functions
	// ------------------------------------------------------------
	function automatic logic io6();
		return osc inside {4'h4, 4'h6, 4'h8};
	endfunction

	function automatic logic io7();
		return osc inside {4'h7, 4'h8};
	endfunction

	function automatic logic [7:0] amask();
		logic [7:0] m;
		m = 8'h00;
		for (int n = 0; n < 5; n++)
			if (int'(sel) + n < 7) m[n == 4 ? 5 : n] = 1'b1;
		return m;
	endfunction

	function automatic logic [7:0] exp_oe();
		logic [7:0] o;
		o = dir;
		o[2] = cv | dir[2];
		o[4] = dir[4] | lat[4];
		o[6] = io6() & dir[6];
		o[7] = ~io7() | dir[7];
		return o;
	endfunction

	function automatic logic [7:0] exp_pin();
		logic [7:0] en;
		en = ~amask() & ~{~io7(), ~io6(), 3'h0, cv, 2'h0};
		return ((~exp_oe() & lat & 8'hEF) | (exp_oe() & ext)) & en;
	endfunction

	task automatic reset_checks();
		lat = 8'h00;
		dir = 8'hFF;
		sel = 4'h0;
		osc = 4'h8;
		cv = 1'b0;
		wb(1'b0, pin_level_port_pkg::OFS_DIR, 8'h00, q);
		chk("dir reset", 8'hFF, q);
		wb(1'b0, pin_level_port_pkg::OFS_LATCH, 8'h00, q);
		chk("latch reset", 8'h00, q);
		wb(1'b0, pin_level_port_pkg::OFS_CONV_CTRL, 8'h00, q);
		chk("conv reset", 8'h00, q);
		chk("analog reset", 8'h2F, {2'b00, asel});
		wb(1'b0, pin_level_port_pkg::OFS_PIN_LEVEL, 8'h00, q);
		chk("pin reset", exp_pin(), q);
		wb(1'b0, pin_level_port_pkg::OFS_OSC_CFG, 8'h00, q);
		chk("osc reset", {4'h0, osc}, q);
	endtask

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		ext <= 8'($random(seed));
		@(posedge clk);
		reset_checks();
		wb(1'b0, 8'h20, 8'h00, q);
		chk("unmapped", 8'h00, q);
		bsel <= 4'hE;
		wb(1'b1, pin_level_port_pkg::OFS_DIR, 8'h00, q);
		bsel <= 4'h1;
		wb(1'b0, pin_level_port_pkg::OFS_DIR, 8'h00, q);
		chk("dir lane off", 8'hFF, q);
		for (int i = 0; i < 36; i++) begin
			lat = 8'($random(seed));
			dir = 8'($random(seed));
			sel = i[3:0];
			osc = 4'(i % 9);
			cv = 1'($random(seed));
			ref_v = 2'($random(seed));
			wb(1'b1, i[0] ? pin_level_port_pkg::OFS_PIN_LEVEL : pin_level_port_pkg::OFS_LATCH,
				lat, q);
			wb(1'b1, pin_level_port_pkg::OFS_DIR, dir, q);
			wb(1'b1, pin_level_port_pkg::OFS_CONV_CTRL, {2'b11, ref_v, sel}, q);
			wb(1'b1, pin_level_port_pkg::OFS_OSC_CFG, {3'h0, cv, osc}, q);
			ext <= 8'($random(seed));
			repeat (4) @(posedge clk);
			wb(1'b0, pin_level_port_pkg::OFS_LATCH, 8'h00, q);
			chk("latch", lat & {io7(), io6(), 6'h3F}, q);
			wb(1'b0, pin_level_port_pkg::OFS_DIR, 8'h00, q);
			chk("dir", dir & {io7(), io6(), 6'h3F}, q);
			wb(1'b0, pin_level_port_pkg::OFS_CONV_CTRL, 8'h00, q);
			chk("conv", {2'b00, ref_v, sel}, q);
			wb(1'b0, pin_level_port_pkg::OFS_OSC_CFG, 8'h00, q);
			chk("osc cfg", {3'h0, cv, osc}, q);
			wb(1'b0, pin_level_port_pkg::OFS_PIN_LEVEL, 8'h00, q);
			chk("pin", exp_pin(), q);
			chk("analog", amask(), {2'b00, asel});
			chk("vref", {6'h00, ref_v}, {6'h00, vsel});
			chk("oe_n", exp_oe(), pin_oe_n);
			w = ~exp_oe() & ~{1'b0, ~io6(), 6'h00};
			chk("out", lat & w & 8'hEF, pin_out & w);
			w = (~exp_oe() & lat & 8'hEF) | (exp_oe() & ext);
			chk("timer", {7'h00, w[4]}, {7'h00, tmr});
			if (!io6()) begin
				hi = 0;
				repeat (8) begin
					@(posedge clk);
					hi += int'(pin_out[6]);
				end
				chk("cycle clock", 8'h04, 8'(hi));
			end
		end
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		reset_checks();
		print_verdict();
	end
endmodule
`default_nettype wire
